//--- verilog/lcr_bank.sv
// Link configuration register bank on the host cpu port
`timescale 1ns/1ns
module lcr_bank #(
   parameter logic [15:0] VERSION = lcr_pkg::LCR_VERSION_DEF, // Arbitrary value
   parameter logic [15:0] REVISION = lcr_pkg::LCR_REVISION_DEF // Arbitrary value
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Host cpu port
   input wire logic [7:0] i_addr,
   input wire logic i_write,
   input wire logic i_read,
   input wire logic [31:0] i_wdata,
   output logic [31:0] o_rdata,
   // Link status
   input wire logic i_root,
   input wire logic i_cable_power,
   input wire logic i_self_id_done_flag,
   input wire logic i_self_id_error,
   input wire logic [5:0] i_node_count,
   input wire logic [5:0] i_contender_phy_id,
   input wire logic i_contender_capable,
   input wire logic [5:0] i_own_phy_id,
   // Received packet header
   input wire logic [9:0] i_rx_dest_bus,
   input wire logic [5:0] i_rx_dest_node,
   input wire logic [3:0] i_rx_tcode,
   input wire logic i_rx_is_self_id,
   // Controls to link core
   output logic o_rx_accept,
   output logic [3:0] o_write_ack,
   output logic o_transmitter_on,
   output logic o_receiver_on,
   output logic o_tx_sync_reset,
   output logic o_rx_sync_reset,
   output logic o_sector_port_wide,
   output logic o_cycle_master_flag,
   output logic o_cycle_source_select,
   output logic o_cycle_offset_count_enable,
   output logic o_self_id_rx_enable,
   output logic [2:0] o_busy_policy,
   output logic o_store_self_id,
   output logic [9:0] o_bus_number,
   output logic [5:0] o_node_number,
   output logic o_lps
);
   import lcr_pkg::*;

   logic [31:0] node_reg;
   logic [31:0] ctrl_reg;
   logic [5:0] lat_count;
   logic [5:0] lat_cont;
   logic done_rise;
   logic diag_write_enable;
   logic [31:0] node_view;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [31:0] mask);
      merge = (old & ~mask) | (nw & mask);
   endfunction

   lcr_selfid_latch u_latch (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_self_id_done_flag(i_self_id_done_flag),
      .i_self_id_error(i_self_id_error),
      .i_node_count(i_node_count),
      .i_contender_phy_id(i_contender_phy_id),
      .i_contender_capable(i_contender_capable),
      .i_own_phy_id(i_own_phy_id),
      .o_done_rise(done_rise),
      .o_node_count(lat_count),
      .o_contender_phy_id(lat_cont)
   );

   // Diagnostic write enable sits in a spare control bit
   assign diag_write_enable = ctrl_reg[LCR_CTL_DIAG_WE];

   // Node word: bus number always writable, rest only in diagnostic mode
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         node_reg <= LCR_NODE_RESET & LCR_NODE_MASK;
      end else if (i_write && i_addr == LCR_OFS_NODE) begin
         node_reg[LCR_NODE_BUS_HI:LCR_NODE_BUS_LO] <= i_wdata[LCR_NODE_BUS_HI:LCR_NODE_BUS_LO];
         if (diag_write_enable) begin
            node_reg[LCR_NODE_ID_HI:0] <= i_wdata[LCR_NODE_ID_HI:0] & LCR_NODE_MASK[21:0];
         end
      end else if (done_rise && !diag_write_enable) begin
         // Self-id results land in the latch fields; diagnostic writes keep priority
         node_reg[LCR_NODE_CNT_HI:LCR_NODE_CNT_LO] <= i_self_id_error ? 6'h00 :
            i_node_count;
         node_reg[LCR_NODE_CONT_HI:LCR_NODE_CONT_LO] <=
            (i_contender_capable && i_own_phy_id > i_contender_phy_id) ? i_own_phy_id :
            i_contender_phy_id;
         node_reg[LCR_NODE_ID_HI:LCR_NODE_ID_LO] <= i_own_phy_id;
      end
   end

   // Live status bits follow the link unless diagnostics override them
   always_comb begin
      node_view = node_reg;
      if (!diag_write_enable) begin
         node_view[LCR_NODE_ROOT] = i_root;
         node_view[LCR_NODE_POWER] = i_cable_power;
         node_view[LCR_NODE_CYCMAS] = o_cycle_master_flag;
         node_view[LCR_NODE_CNT_HI:LCR_NODE_CNT_LO] = lat_count;
         node_view[LCR_NODE_CONT_HI:LCR_NODE_CONT_LO] = lat_cont;
      end
      node_view = node_view & LCR_NODE_MASK;
   end

   // Control word; reset bits clear themselves one cycle after being set
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_reg <= LCR_CTRL_RESET;
      end else if (i_write && i_addr == LCR_OFS_CONTROL) begin
         ctrl_reg <= merge(ctrl_reg, i_wdata, LCR_CTRL_MASK);
      end else begin
         ctrl_reg[LCR_CTL_TX_RST] <= 1'b0;
         ctrl_reg[LCR_CTL_RX_RST] <= 1'b0;
      end
   end

   // Read data registered, one cycle after the read strobe
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= 32'h00000000;
      end else if (i_read) begin
         case (i_addr)
            LCR_OFS_VERSION: o_rdata <= {VERSION, REVISION};
            LCR_OFS_NODE: o_rdata <= node_view;
            LCR_OFS_CONTROL: o_rdata <= {ctrl_reg[31], 1'b1, 3'b000, ctrl_reg[26:11],
                                         1'b0, 1'b1, ctrl_reg[8:0]};
            default: o_rdata <= 32'h00000000;
         endcase
      end
   end

   // Controls to the link core
   assign o_transmitter_on = ctrl_reg[LCR_CTL_TX_ON];
   assign o_receiver_on = ctrl_reg[LCR_CTL_RX_ON];
   assign o_tx_sync_reset = ctrl_reg[LCR_CTL_TX_RST];
   assign o_rx_sync_reset = ctrl_reg[LCR_CTL_RX_RST];
   assign o_sector_port_wide = ctrl_reg[LCR_CTL_WIDE];
   assign o_cycle_master_flag = ctrl_reg[LCR_CTL_CM_ALLOW] & i_root;
   assign o_cycle_source_select = 1'b0;
   assign o_cycle_offset_count_enable = 1'b1;
   assign o_self_id_rx_enable = 1'b1;
   assign o_busy_policy = 3'b000;
   assign o_lps = ctrl_reg[LCR_CTL_LPS];
   assign o_bus_number = node_reg[LCR_NODE_BUS_HI:LCR_NODE_BUS_LO];
   assign o_node_number = node_reg[LCR_NODE_ID_HI:LCR_NODE_ID_LO];

   // Self-id packets reach the buffer only when storing is on and reception is on
   assign o_store_self_id = ctrl_reg[LCR_CTL_STORE_SID] & i_rx_is_self_id &
                            ctrl_reg[LCR_CTL_RX_ON];

   // Address filter for incoming packets
   always_comb begin
      o_rx_accept = 1'b0;
      if (ctrl_reg[LCR_CTL_RX_ON]) begin
         if (i_rx_dest_bus == LCR_BCAST_BUS && i_rx_dest_node == LCR_BCAST_NODE) begin
            o_rx_accept = 1'b1;
         end else if (ctrl_reg[LCR_CTL_OWN_ADDR] && i_rx_dest_bus == o_bus_number &&
                      i_rx_dest_node == o_node_number) begin
            o_rx_accept = 1'b1;
         end
      end
   end

   // Acknowledge for write requests
   always_comb begin
      if (i_rx_tcode == LCR_TCODE_WQ || i_rx_tcode == LCR_TCODE_WB) begin
         o_write_ack = ctrl_reg[LCR_CTL_ACK] ? LCR_ACK_PENDING : LCR_ACK_COMPLETE;
      end else begin
         o_write_ack = 4'h0;
      end
   end
endmodule // lcr_bank

//--- verilog/lcr_pkg.sv
// Package of offsets, fields and reset values for the link configuration bank
package lcr_pkg;
   localparam logic [7:0] LCR_OFS_VERSION = 8'h00;
   localparam logic [7:0] LCR_OFS_NODE = 8'h04;
   localparam logic [7:0] LCR_OFS_CONTROL = 8'h08;
   localparam logic [15:0] LCR_VERSION_DEF = 16'h0001;
   localparam logic [15:0] LCR_REVISION_DEF = 16'h0000;
   localparam logic [31:0] LCR_NODE_RESET = 32'hFFFF0000;
   localparam logic [31:0] LCR_CTRL_RESET = 32'hC6002A01;
   localparam logic [31:0] LCR_NODE_MASK = 32'hFFFFEFFF;
   // Bit 24 is writable as well: it holds the diagnostic write enable
   localparam logic [31:0] LCR_CTRL_MASK = 32'hFF303E09;
   localparam int LCR_NODE_BUS_HI = 31;
   localparam int LCR_NODE_BUS_LO = 22;
   localparam int LCR_NODE_ID_HI = 21;
   localparam int LCR_NODE_ID_LO = 16;
   localparam int LCR_NODE_ROOT = 15;
   localparam int LCR_NODE_POWER = 14;
   localparam int LCR_NODE_CYCMAS = 13;
   localparam int LCR_NODE_CNT_HI = 11;
   localparam int LCR_NODE_CNT_LO = 6;
   localparam int LCR_NODE_CONT_HI = 5;
   localparam int LCR_NODE_CONT_LO = 0;
   localparam int LCR_CTL_OWN_ADDR = 31;
   localparam int LCR_CTL_SELFID_RX = 30;
   localparam int LCR_CTL_BUSY_HI = 29;
   localparam int LCR_CTL_BUSY_LO = 27;
   localparam int LCR_CTL_TX_ON = 26;
   localparam int LCR_CTL_RX_ON = 25;
   localparam int LCR_CTL_DIAG_WE = 24;
   localparam int LCR_CTL_TX_RST = 21;
   localparam int LCR_CTL_RX_RST = 20;
   localparam int LCR_CTL_WIDE = 13;
   localparam int LCR_CTL_ACK = 12;
   localparam int LCR_CTL_CM_ALLOW = 11;
   localparam int LCR_CTL_CYC_SRC = 10;
   localparam int LCR_CTL_CYC_CNT = 9;
   localparam int LCR_CTL_STORE_SID = 3;
   localparam int LCR_CTL_LPS = 0;
   localparam logic [9:0] LCR_BCAST_BUS = 10'h3FF;
   localparam logic [5:0] LCR_BCAST_NODE = 6'h3F;
   localparam logic [3:0] LCR_ACK_COMPLETE = 4'h1;
   localparam logic [3:0] LCR_ACK_PENDING = 4'h2;
   localparam logic [3:0] LCR_TCODE_WQ = 4'h0;
   localparam logic [3:0] LCR_TCODE_WB = 4'h1;
endpackage

//--- verilog/lcr_selfid_latch.sv
// Latch of node count and contender id at the end of the self-id phase
`timescale 1ns/1ns
module lcr_selfid_latch (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Self-id results
   input wire logic i_self_id_done_flag,
   input wire logic i_self_id_error,
   input wire logic [5:0] i_node_count,
   input wire logic [5:0] i_contender_phy_id,
   input wire logic i_contender_capable,
   input wire logic [5:0] i_own_phy_id,
   // Done edge and latched values
   output logic o_done_rise,
   output logic [5:0] o_node_count,
   output logic [5:0] o_contender_phy_id
);
   logic done_reg;
   assign o_done_rise = i_self_id_done_flag & ~done_reg;
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= i_self_id_done_flag;
      end
   end
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_node_count <= 6'h00;
         o_contender_phy_id <= 6'h00;
      end else if (o_done_rise) begin
         o_node_count <= i_self_id_error ? 6'h00 : i_node_count;
         if (i_contender_capable && (i_own_phy_id > i_contender_phy_id)) begin
            o_contender_phy_id <= i_own_phy_id;
         end else begin
            o_contender_phy_id <= i_contender_phy_id;
         end
      end
   end
endmodule // lcr_selfid_latch

//--- sim/lcr_host.sv
// Host cpu model that drives the bank's register port
`timescale 1ns/1ns
module lcr_host (
   // Clock
   input wire logic i_clock,
   // Register port
   output logic [7:0] o_addr,
   output logic o_write,
   output logic o_read,
   output logic [31:0] o_wdata,
   input wire logic [31:0] i_rdata
);
   initial begin
      o_addr = 8'h00;
      o_write = 1'b0;
      o_read = 1'b0;
      o_wdata = 32'h00000000;
   end
   // Each access waits an edge first, so a strobe never drops and rises in one step
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge i_clock);
      #1;
      o_addr = a;
      o_wdata = v;
      o_write = 1'b1;
      @(posedge i_clock);
      #1;
      o_write = 1'b0;
      o_addr = ~a;
      o_wdata = ~v;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge i_clock);
      #1;
      o_addr = a;
      o_read = 1'b1;
      @(posedge i_clock);
      #1;
      o_read = 1'b0;
      o_addr = ~a;
      @(posedge i_clock);
      #1;
      v = i_rdata;
   endtask
endmodule // lcr_host

//--- sim/lcr_bank_chk.sv
// Port checker of the link configuration register bank
`timescale 1ns/1ns
module lcr_bank_chk
   import lcr_pkg::*;
#(
   parameter logic [15:0] VERSION = LCR_VERSION_DEF,
   parameter logic [15:0] REVISION = LCR_REVISION_DEF
) (
   // Watched ports
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [7:0] i_addr,
   input wire logic i_write,
   input wire logic i_read,
   input wire logic [31:0] i_wdata,
   input wire logic [31:0] o_rdata,
   input wire logic [9:0] i_rx_dest_bus,
   input wire logic [5:0] i_rx_dest_node,
   input wire logic o_rx_accept,
   input wire logic o_receiver_on,
   input wire logic o_tx_sync_reset,
   input wire logic o_rx_sync_reset,
   input wire logic o_lps
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   wire wr_ctl = i_write && i_addr == 8'h08;
   property p_lps; wr_ctl |=> o_lps == $past(i_wdata[0]); endproperty
   a_lps: assert property (p_lps) else $error("lps pin wrong");
   property p_txp; wr_ctl && i_wdata[21] |=> o_tx_sync_reset; endproperty
   a_txp: assert property (p_txp) else $error("tx reset missing");
   property p_txc; o_tx_sync_reset && !(wr_ctl && i_wdata[21]) |=> !o_tx_sync_reset; endproperty
   a_txc: assert property (p_txc) else $error("tx reset stuck");
   property p_rxp; wr_ctl && i_wdata[20] |=> o_rx_sync_reset; endproperty
   a_rxp: assert property (p_rxp) else $error("rx reset missing");
   property p_ver; i_read && i_addr == 8'h00 |=> o_rdata == {VERSION, REVISION}; endproperty
   a_ver: assert property (p_ver) else $error("id word wrong");
   property p_ctl;
      i_read && i_addr == 8'h08 |=> o_rdata[30] && o_rdata[29:27] == 3'b000
         && o_rdata[10:9] == 2'b01 && (o_rdata & ~(LCR_CTRL_MASK | 32'h01000000)) == 0;
   endproperty
   a_ctl: assert property (p_ctl) else $error("control read wrong");
   property p_hold; !i_read |=> $stable(o_rdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_bcast;
      o_receiver_on && i_rx_dest_bus == 10'h3FF && i_rx_dest_node == 6'h3F |-> o_rx_accept;
   endproperty
   a_bcast: assert property (p_bcast) else $error("broadcast refused");
   property p_rxoff; !o_receiver_on |-> !o_rx_accept; endproperty
   a_rxoff: assert property (p_rxoff) else $error("accept while off");
   c_txr: cover property (wr_ctl && i_wdata[21]);
   c_node: cover property (i_read && i_addr == 8'h04);
   c_off: cover property (!o_receiver_on);
   c_diag: cover property (wr_ctl && i_wdata[24]);
endmodule // lcr_bank_chk
bind lcr_bank lcr_bank_chk #(.VERSION(VERSION), .REVISION(REVISION)) u_chk (.*);

//--- sim/test_link_config_register_bank.sv
// Self-checking bench of the link configuration register bank
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_fail++; \
   $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module test_link_config_register_bank;
   import lcr_pkg::*;
   logic i_clock = 1'b0, i_rst_n = 1'b0, i_write, i_read, i_root = 1'b0, i_cable_power = 1'b0;
   logic i_self_id_done_flag = 1'b0, i_self_id_error = 1'b0, i_contender_capable = 1'b0;
   logic i_rx_is_self_id = 1'b1, o_rx_accept, o_transmitter_on, o_receiver_on, o_lps;
   logic o_tx_sync_reset, o_rx_sync_reset, o_sector_port_wide, o_cycle_master_flag;
   logic o_cycle_source_select, o_cycle_offset_count_enable, o_self_id_rx_enable, o_store_self_id;
   logic [7:0] i_addr;
   logic [31:0] i_wdata, o_rdata, d;
   logic [5:0] i_node_count = 6'h05, i_contender_phy_id = 6'h07, i_own_phy_id = 6'h03;
   logic [5:0] i_rx_dest_node = 6'h09, o_node_number;
   logic [9:0] i_rx_dest_bus = 10'h000, o_bus_number;
   logic [3:0] i_rx_tcode = 4'h0, o_write_ack;
   logic [2:0] o_busy_policy;
   int n_fail = 0, n_checks = 0, cycles = 0;
   always #2 i_clock = ~i_clock;
   lcr_bank #(.VERSION(16'h00A5), .REVISION(16'h0003)) dut (.*);
   lcr_host u_host (.i_clock(i_clock), .o_addr(i_addr), .o_write(i_write), .o_read(i_read),
      .o_wdata(i_wdata), .i_rdata(o_rdata));
   task automatic rdc(input logic [7:0] a, input logic [31:0] ex);
      u_host.rd(a, d);
      `CHK("rdata", ex, d)
   endtask
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Whole run needs well under 300 cycles
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 2000) begin
         n_fail++;
         finish_test();
      end
   end
   initial begin
      repeat (5) @(posedge i_clock);
      #1 i_rst_n = 1'b1;
      rdc(8'h00, 32'h00A50003);
      u_host.wr(8'h00, 32'hFFFFFFFF);
      rdc(8'h00, 32'h00A50003);
      rdc(8'h08, LCR_CTRL_RESET);
      rdc(8'h0C, 32'h00000000);
      i_root = 1'b1;
      i_cable_power = 1'b1;
      rdc(8'h04, 32'hFFFFE000);
      u_host.wr(8'h04, 32'h00000000);
      rdc(8'h04, 32'h003FE000);
      i_self_id_done_flag = 1'b1;
      rdc(8'h04, 32'h0003E147);
      i_self_id_done_flag = 1'b0;
      i_self_id_error = 1'b1;
      i_contender_capable = 1'b1;
      i_own_phy_id = 6'h09;
      u_host.wr(8'h0C, 32'hFFFFFFFF);
      i_self_id_done_flag = 1'b1;
      rdc(8'h04, 32'h0009E009);
      `CHK("accept", 1'b1, o_rx_accept)
      `CHK("ack", LCR_ACK_COMPLETE, o_write_ack)
      `CHK("store", 1'b0, o_store_self_id)
      u_host.wr(8'h08, 32'h46003A09);
      `CHK("accept", 1'b0, o_rx_accept)
      `CHK("ack", LCR_ACK_PENDING, o_write_ack)
      `CHK("store", 1'b1, o_store_self_id)
      i_rx_dest_bus = 10'h3FF;
      i_rx_dest_node = 6'h3F;
      i_rx_tcode = 4'h4;
      u_host.wr(8'h08, 32'hFFFFFFFF);
      `CHK("accept", 1'b1, o_rx_accept)
      `CHK("ack", 4'h0, o_write_ack)
      `CHK("resets", 2'b11, {o_tx_sync_reset, o_rx_sync_reset})
      `CHK("pins", 5'h1F, {o_lps, o_transmitter_on, o_receiver_on, o_sector_port_wide,
         o_cycle_master_flag})
      `CHK("fixed", 6'h18, {o_cycle_source_select, o_cycle_offset_count_enable,
         o_self_id_rx_enable, o_busy_policy})
      // Allowed but not root: cycle master must stay off
      i_root = 1'b0;
      #1;
      `CHK("cycle master", 1'b0, o_cycle_master_flag)
      u_host.rd(8'h08, d);
      `CHK("resets", 2'b00, {o_tx_sync_reset, o_rx_sync_reset})
      `CHK("control", 32'hC6003A09, d & 32'hFEFFFFFF)
      u_host.wr(8'h08, 32'h00000000);
      `CHK("pins", 6'h00, {o_lps, o_transmitter_on, o_receiver_on, o_sector_port_wide,
         o_cycle_master_flag, o_rx_accept})
      rdc(8'h08, 32'h40000200);
      // Live status low: root, power and cycle master bits must read 0
      i_cable_power = 1'b0;
      rdc(8'h04, 32'h00090009);
      u_host.wr(8'h08, 32'h01000000);
      u_host.wr(8'h04, 32'hFFFFFFFF);
      rdc(8'h04, 32'hFFFFEFFF);
      `CHK("node", 16'hFFFF, {o_bus_number, o_node_number})
      finish_test();
   end
endmodule // test_link_config_register_bank
